// [ecp_port_cfg.svh]
// register offsets, field positions, reset values and mode codes
`ifndef ECP_PORT_CFG_SVH
`define ECP_PORT_CFG_SVH

// ============================================================
// bus geometry and answers
`define ADDR_W        8
`define RESP_OKAY     2'b00
`define RESP_SLVERR   2'b10

// ============================================================
// register byte offsets
`define OFS_DATA      8'h00
`define OFS_STATUS    8'h04
`define OFS_CONTROL   8'h08
`define OFS_FIFO      8'h0C
`define OFS_AFIFO     8'h10
`define OFS_CAPA      8'h14
`define OFS_CAPB      8'h18
`define OFS_ECR       8'h1C
`define OFS_THR       8'h20

// ============================================================
// extended control fields
`define ECR_MODE_HI   7
`define ECR_MODE_LO   5
`define ECR_FLTDIS    4
`define ECR_DMA       3
`define ECR_SVC       2
`define ECR_RESET     8'h14

// ============================================================
// line control fields
`define CTL_DIR       5
`define CTL_ACKIRQ    4
`define CTL_SELIN     3
`define CTL_INIT      2
`define CTL_AFD       1
`define CTL_STB       0
`define CTL_RESET     6'h04

// ============================================================
// mode encodings
`define MODE_STD      3'b000
`define MODE_BIDIR    3'b001
`define MODE_COMPAT_FIFO_PORT    3'b010
`define MODE_ECP      3'b011
`define MODE_EPP      3'b100
`define MODE_TEST     3'b110
`define MODE_CFG      3'b111

// ============================================================
// fixed read values, fifo size, threshold reset
`define CAPA_VALUE    8'h10
`define CAPB_ONES     6'h3F
`define STATUS_ONES   3'h7
`define CTL_ONES      2'h3
`define FIFO_DEPTH    16
`define THR_RESET     5'h08

`endif

// [ecp_port_pkg.sv]
// types shared by the parallel port controller and its fifo
package ecp_port_pkg;

	// handshake sequencer states
	typedef enum logic [1:0] {
		HS_IDLE,
		HS_FWD_STROBE,
		HS_REV_WAIT,
		HS_REV_ACK
	} hs_state_e;

	// one fifo entry: command tag and byte
	typedef struct packed {
		logic       cmd;
		logic [7:0] data;
	} fifo_entry_s;

	// pin inputs after synchronising
	typedef struct packed {
		logic       busy;
		logic       ack_n;
		logic       perror;
		logic       select;
		logic       fault_n;
		logic [7:0] pd;
	} pin_in_s;

endpackage

// [shared_byte_fifo.sv]
// flip-flop fifo shared by every fifo view of the port
`timescale 1ns/1ns
`default_nettype none

module shared_byte_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16,
	localparam int AW = $clog2(DEPTH),
	localparam int CW = AW + 1
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             flush,
	input  wire logic             push,
	input  wire logic [WIDTH-1:0] push_data,
	input  wire logic             pop,
	output logic      [WIDTH-1:0] head,
	output logic                  full,
	output logic                  empty,
	output logic      [CW-1:0]    fill
);

	// ========================================================
	// elaboration check
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
		$error("fifo depth must be a power of two, at least 2");
	end

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [WIDTH-1:0] mem_next [DEPTH];
	logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
	logic [CW-1:0]    cnt_reg, cnt_next;
	logic             do_push, do_pop;

	// flags come from the count, so they settle the cycle after
	assign full    = (cnt_reg == CW'(DEPTH));
	assign empty   = (cnt_reg == '0);
	assign fill    = cnt_reg;
	assign head    = mem_reg[rd_reg];
	assign do_push = push & ~full;
	assign do_pop  = pop & ~empty;

	// ========================================================
	// pointer and storage update; flush wins over traffic
	always_comb begin
		mem_next = mem_reg;
		wr_next  = wr_reg;
		rd_next  = rd_reg;
		cnt_next = cnt_reg;
		if (flush) begin
			wr_next  = '0;
			rd_next  = '0;
			cnt_next = '0;
		end else begin
			if (do_push) begin
				mem_next[wr_reg] = push_data;
				wr_next = wr_reg + AW'(1);
			end
			if (do_pop)
				rd_next = rd_reg + AW'(1);
			cnt_next = cnt_reg + CW'(do_push) - CW'(do_pop);
		end
	end

	// storage needs no reset, only the pointers and the count do
	always_ff @(posedge clk) begin
		mem_reg <= mem_next;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
		end else begin
			wr_reg  <= wr_next;
			rd_reg  <= rd_next;
			cnt_reg <= cnt_next;
		end
	end

endmodule // shared_byte_fifo

`default_nettype wire

// [ecp_parallel_port_fifo_ctrl.sv]
// extended parallel port controller: registers, shared fifo, handshake
`timescale 1ns/1ns
`default_nettype none
`include "ecp_port_cfg.svh"

// ============================================================

module ecp_parallel_port_fifo_ctrl
	import ecp_port_pkg::*;
#(
	parameter int DEPTH = `FIFO_DEPTH
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [`ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [`ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	input  wire logic [7:0]        pd_in,
	output logic      [7:0]        pd_out,
	output logic                   pd_oe,
	output logic                   strobe_n,
	output logic                   autofd_n,
	output logic                   init_n,
	output logic                   selectin_n,
	input  wire logic              busy,
	input  wire logic              ack_n,
	input  wire logic              perror,
	input  wire logic              select,
	input  wire logic              fault_n,
	input  wire logic              dma_tc,
	input  wire logic              irq_line_level,
	output logic                   dma_req,
	output logic                   irq
);

	localparam int CW = $clog2(DEPTH) + 1;

	// thresholds are five bits wide, so the fifo may not exceed 16
	if (DEPTH < 2 || DEPTH > 16 || (DEPTH & (DEPTH - 1)) != 0)
	begin : g_chk
		$error("DEPTH must be a power of two from 2 to 16");
	end

	// ========================================================
	// declarations
	pin_in_s     pin_raw, meta_reg, meta_next, sync_reg, sync_next;
	pin_in_s     prev_reg, prev_next;
	logic [7:0]  data_reg, data_next;
	logic [5:0]  ctl_reg, ctl_next;
	logic [2:0]  mode_reg, mode_next;
	logic        fdis_reg, fdis_next, dma_reg, dma_next;
	logic        svc_reg, svc_next;
	logic [4:0]  thr_free_reg, thr_free_next;
	logic [4:0]  thr_fill_reg, thr_fill_next;
	logic        bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
	logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic        irq_reg, irq_next;
	hs_state_e   hs_reg, hs_next;
	logic [7:0]  odata_reg, odata_next;
	logic        stb_reg, stb_next, afd_reg, afd_next;
	fifo_entry_s sw_entry, hs_entry, push_entry, head;
	logic        sw_push, hs_push, sw_pop, hs_pop, push, pop;
	logic        full, empty, flush, wr_go, rd_go;
	logic [CW-1:0] fill;
	logic [4:0]  fill5, free5;
	logic        dir_eff, auto_mode, fwd_auto, rev_auto, is_ecp;
	logic        svc_cond, fault_fall, ack_rise;

	// offsets are word aligned and contiguous up to thresholds
	function automatic logic known_ofs(input logic [`ADDR_W-1:0] a);
		return (a[1:0] == 2'b00) && (a <= `OFS_THR);
	endfunction

	// standard or bidir may go anywhere; others only back to them
	function automatic logic mode_ok(input logic [2:0] cur,
	                                 input logic [2:0] nxt);
		return (cur == `MODE_STD) || (cur == `MODE_BIDIR) ||
		       (nxt == `MODE_STD) || (nxt == `MODE_BIDIR);
	endfunction

	// ========================================================
	// pin synchroniser: two flops, then a third for edges
	assign pin_raw = '{busy: busy, ack_n: ack_n, perror: perror,
	                   select: select, fault_n: fault_n, pd: pd_in};

	always_comb begin
		meta_next = pin_raw;
		sync_next = meta_reg;
		prev_next = sync_reg;
	end

	// idle cable levels are high, so reset to ones avoids false edges
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_reg <= '1;
			sync_reg <= '1;
			prev_reg <= '1;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
			prev_reg <= prev_next;
		end
	end

	// ========================================================
	// mode decode
	assign is_ecp    = (mode_reg == `MODE_ECP);
	assign dir_eff   = ctl_reg[`CTL_DIR] && (mode_reg != `MODE_STD) &&
	                   (mode_reg != `MODE_COMPAT_FIFO_PORT);
	assign auto_mode = is_ecp || (mode_reg == `MODE_COMPAT_FIFO_PORT);
	assign fwd_auto  = auto_mode && !dir_eff;
	assign rev_auto  = is_ecp && dir_eff;
	assign flush     = (mode_reg == `MODE_STD);
	assign fill5     = 5'(fill);
	assign free5     = 5'(DEPTH) - fill5;

	// ========================================================
	// service condition and interrupt events
	always_comb begin
		if (dma_reg)
			svc_cond = dma_tc;
		else if (dir_eff)
			svc_cond = (fill5 >= thr_fill_reg);
		else
			svc_cond = (free5 >= thr_free_reg);
	end

	// fault only counts in forward ecp with its disable clear
	assign fault_fall = prev_reg.fault_n && !sync_reg.fault_n &&
	                    is_ecp && !dir_eff && !fdis_reg;
	assign ack_rise   = !prev_reg.ack_n && sync_reg.ack_n &&
	                    ctl_reg[`CTL_ACKIRQ];

	// dma asks only while the service flag is clear
	assign dma_req = dma_reg && !svc_reg && auto_mode &&
	                 (dir_eff ? !empty : !full);

	// ========================================================
	// axi handshakes: write takes address and data together
	assign wr_go   = awvalid && wvalid && !bvalid_reg;
	assign awready = wr_go;
	assign wready  = wr_go;
	assign rd_go   = arvalid && !rvalid_reg;
	assign arready = rd_go;
	assign bvalid  = bvalid_reg;
	assign bresp   = bresp_reg;
	assign rvalid  = rvalid_reg;
	assign rresp   = rresp_reg;
	assign rdata   = rdata_reg;
	assign irq     = irq_reg;

	// ========================================================
	// register file, bus answers, software fifo traffic
	always_comb begin
		data_next     = data_reg;
		ctl_next      = ctl_reg;
		mode_next     = mode_reg;
		fdis_next     = fdis_reg;
		dma_next      = dma_reg;
		svc_next      = svc_reg;
		thr_free_next = thr_free_reg;
		thr_fill_next = thr_fill_reg;
		bvalid_next   = bvalid_reg && !bready;
		bresp_next    = bresp_reg;
		rvalid_next   = rvalid_reg && !rready;
		rresp_next    = rresp_reg;
		rdata_next    = rdata_reg;
		sw_push       = 1'b0;
		sw_pop        = 1'b0;
		sw_entry      = '0;
		if (wr_go) begin
			bvalid_next = 1'b1;
			bresp_next  = known_ofs(awaddr) ? `RESP_OKAY : `RESP_SLVERR;
			if (wstrb[0]) begin
				unique case (awaddr)
					`OFS_DATA: data_next = wdata[7:0];
					`OFS_CONTROL: begin
						ctl_next[4:0] = wdata[4:0];
						if (mode_reg == `MODE_BIDIR)
							ctl_next[`CTL_DIR] = wdata[`CTL_DIR];
					end
					`OFS_FIFO: begin
						// one store behind every byte view
						if (fwd_auto || mode_reg == `MODE_TEST) begin
							sw_push  = 1'b1;
							sw_entry = '{cmd: 1'b0, data: wdata[7:0]};
						end
					end
					`OFS_AFIFO: begin
						// forward ecp only; bytes carry the command tag
						if (is_ecp && !dir_eff) begin
							sw_push  = 1'b1;
							sw_entry = '{cmd: 1'b1, data: wdata[7:0]};
						end
					end
					`OFS_ECR: begin
						if (mode_ok(mode_reg,
						            wdata[`ECR_MODE_HI:`ECR_MODE_LO]))
							mode_next = wdata[`ECR_MODE_HI:`ECR_MODE_LO];
						fdis_next = wdata[`ECR_FLTDIS];
						dma_next  = wdata[`ECR_DMA];
						svc_next  = wdata[`ECR_SVC];
					end
					`OFS_THR: begin
						thr_free_next = wdata[4:0];
						thr_fill_next = wdata[12:8];
					end
					default: ;
				endcase
			end
		end
		// hardware set comes after the write, so it wins a clash
		if (!svc_reg && svc_cond)
			svc_next = 1'b1;
		if (rd_go) begin
			rvalid_next = 1'b1;
			rresp_next  = known_ofs(araddr) ? `RESP_OKAY : `RESP_SLVERR;
			unique case (araddr)
				`OFS_DATA: rdata_next = {24'h0, (mode_reg == `MODE_BIDIR)
				                         ? sync_reg.pd : data_reg};
				`OFS_STATUS: rdata_next = {24'h0, !sync_reg.busy,
					sync_reg.ack_n, sync_reg.perror, sync_reg.select,
					sync_reg.fault_n, `STATUS_ONES};
				`OFS_CONTROL: rdata_next = {24'h0, `CTL_ONES, ctl_reg};
				`OFS_FIFO: begin
					rdata_next = '0;
					if ((rev_auto || mode_reg == `MODE_TEST) && !empty) begin
						rdata_next = {24'h0, head.data};
						sw_pop     = 1'b1;
					end
				end
				`OFS_ECR: rdata_next = {24'h0, mode_reg, fdis_reg, dma_reg,
				                       svc_reg, full, empty};
				`OFS_CAPA: rdata_next = (mode_reg == `MODE_CFG) ?
				                        {24'h0, `CAPA_VALUE} : '0;
				`OFS_CAPB: rdata_next = (mode_reg == `MODE_CFG) ?
				           {24'h0, 1'b0, irq_line_level, `CAPB_ONES} : '0;
				`OFS_THR: rdata_next = {19'h0, thr_fill_reg, 3'h0,
				                        thr_free_reg};
				default: rdata_next = '0;
			endcase
		end
		// service pulse is gated by the flag itself
		irq_next = (!svc_reg && svc_cond) || fault_fall || ack_rise;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			data_reg     <= '0;
			ctl_reg      <= `CTL_RESET;
			mode_reg     <= 3'(`ECR_RESET >> `ECR_MODE_LO);
			fdis_reg     <= 1'(`ECR_RESET >> `ECR_FLTDIS);
			dma_reg      <= 1'(`ECR_RESET >> `ECR_DMA);
			svc_reg      <= 1'(`ECR_RESET >> `ECR_SVC);
			thr_free_reg <= `THR_RESET;
			thr_fill_reg <= `THR_RESET;
			bvalid_reg   <= 1'b0;
			bresp_reg    <= `RESP_OKAY;
			rvalid_reg   <= 1'b0;
			rresp_reg    <= `RESP_OKAY;
			rdata_reg    <= '0;
			irq_reg      <= 1'b0;
		end else begin
			data_reg     <= data_next;
			ctl_reg      <= ctl_next;
			mode_reg     <= mode_next;
			fdis_reg     <= fdis_next;
			dma_reg      <= dma_next;
			svc_reg      <= svc_next;
			thr_free_reg <= thr_free_next;
			thr_fill_reg <= thr_fill_next;
			bvalid_reg   <= bvalid_next;
			bresp_reg    <= bresp_next;
			rvalid_reg   <= rvalid_next;
			rresp_reg    <= rresp_next;
			rdata_reg    <= rdata_next;
			irq_reg      <= irq_next;
		end
	end

	// ========================================================
	// automatic cable handshake
	always_comb begin
		hs_next    = hs_reg;
		odata_next = odata_reg;
		stb_next   = stb_reg;
		afd_next   = afd_reg;
		hs_pop     = 1'b0;
		hs_push    = 1'b0;
		hs_entry   = '{cmd: !sync_reg.busy, data: sync_reg.pd};
		unique case (hs_reg)
			HS_IDLE: begin
				if (fwd_auto && !empty && !sync_reg.busy) begin
					// byte, tag and strobe out in the same cycle; pop frees the slot
					odata_next = head.data;
					afd_next   = !head.cmd;
					stb_next   = 1'b1;
					hs_pop     = 1'b1;
					hs_next    = HS_FWD_STROBE;
				end else if (rev_auto && !sync_reg.perror && !full) begin
					afd_next = 1'b0;
					hs_next  = HS_REV_WAIT;
				end
			end
			HS_FWD_STROBE: begin
				// busy high means taken; release waits for busy high
				if (!fwd_auto || sync_reg.busy) begin
					stb_next = 1'b0;
					hs_next  = HS_IDLE;
				end
			end
			HS_REV_WAIT: begin
				if (!rev_auto) begin
					afd_next = 1'b1;
					hs_next  = HS_IDLE;
				end else if (!sync_reg.ack_n) begin
					hs_push  = 1'b1;
					afd_next = 1'b1;
					hs_next  = HS_REV_ACK;
				end
			end
			HS_REV_ACK: begin
				if (!rev_auto || sync_reg.ack_n)
					hs_next = HS_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hs_reg    <= HS_IDLE;
			odata_reg <= '0;
			stb_reg   <= 1'b0;
			afd_reg   <= 1'b1;
		end else begin
			hs_reg    <= hs_next;
			odata_reg <= odata_next;
			stb_reg   <= stb_next;
			afd_reg   <= afd_next;
		end
	end

	// ========================================================
	// shared fifo; cable and bus pushes, and their pops, never meet in one mode
	assign push       = sw_push || hs_push;
	assign pop        = sw_pop || hs_pop;
	assign push_entry = hs_push ? hs_entry : sw_entry;

	shared_byte_fifo #(
		.WIDTH ($bits(fifo_entry_s)),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk       (aclk),
		.rst_n     (aresetn),
		.flush     (flush),
		.push      (push),
		.push_data (push_entry),
		.pop       (pop),
		.head      (head),
		.full      (full),
		.empty     (empty),
		.fill      (fill)
	);

	// ========================================================
	// cable outputs
	assign pd_out     = fwd_auto ? odata_reg : data_reg;
	// in ecp the bus is driven only while perror grants forward
	assign pd_oe      = !dir_eff && (!is_ecp || sync_reg.perror);
	assign strobe_n   = auto_mode ? !stb_reg : !ctl_reg[`CTL_STB];
	assign autofd_n   = is_ecp ? afd_reg : !ctl_reg[`CTL_AFD];
	assign init_n     = is_ecp ? !dir_eff : ctl_reg[`CTL_INIT];
	assign selectin_n = !ctl_reg[`CTL_SELIN];

endmodule // ecp_parallel_port_fifo_ctrl

`default_nettype wire

// [ecp_port_assertions.sv]
// port checker for the parallel port controller
`timescale 1ns/1ns
`default_nettype none

// ============================================================
// checker bound onto the controller ports
module ecp_port_checker #(
	parameter int DEPTH = 16
) (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        awvalid,
	input wire logic        wvalid,
	input wire logic        awready,
	input wire logic        bvalid,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic [7:0]  araddr,
	input wire logic        rvalid,
	input wire logic        rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0]  rresp,
	input wire logic [7:0]  pd_out,
	input wire logic        pd_oe,
	input wire logic        strobe_n,
	input wire logic        autofd_n,
	input wire logic        init_n,
	input wire logic        busy,
	input wire logic        ack_n
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// bus takes, one step each
	sequence s_wr;
		awvalid && wvalid && awready;
	endsequence
	sequence s_rd(logic [7:0] a);
		arvalid && arready && araddr == a;
	endsequence

	AST_WR_ANSWER: assert property (s_wr |=> bvalid)
		else $error("write not answered");
	AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read answer dropped");
	AST_STATUS: assert property (s_rd(8'h04) |=> rdata[2:0] == 3'h7)
		else $error("status low bits wrong");
	AST_UNMAPPED: assert property (s_rd(8'h24) |=> rresp == 2'h2 && rdata == 0)
		else $error("unmapped read not refused");
	// raw busy low means the sync copy is low too, so no early release
	AST_STB_HOLD: assert property (!strobe_n && !busy |=> !strobe_n)
		else $error("strobe released before busy");
	AST_PD_STEADY: assert property (!strobe_n && $past(!strobe_n) |-> $stable(pd_out))
		else $error("data moved under strobe");
	AST_REV_NO_DRIVE: assert property (!init_n && !autofd_n |-> !pd_oe)
		else $error("data lines driven in reverse");
	AST_REV_INTERLOCK: assert property (!pd_oe && !autofd_n && !ack_n |-> ##[1:6] autofd_n)
		else $error("byte request not withdrawn");
endmodule // ecp_port_checker

bind ecp_parallel_port_fifo_ctrl ecp_port_checker #(.DEPTH(DEPTH)) checker_i (
	.aclk, .aresetn, .awvalid, .wvalid, .awready, .bvalid, .arvalid,
	.arready, .araddr, .rvalid, .rready, .rdata, .rresp, .pd_out, .pd_oe,
	.strobe_n, .autofd_n, .init_n, .busy, .ack_n
);
`default_nettype wire

// [periph_model.sv]
// behavioural peripheral at the far end of the cable
`timescale 1ns/1ns
`default_nettype none

// ============================================================
// peripheral paced by its own link clock
module periph_model (
	input wire logic       pclk,
	input wire logic       stall,
	input wire logic       strobe_n,
	input wire logic       autofd_n,
	input wire logic       init_n,
	input wire logic [7:0] pd_out,
	output logic           busy,
	output logic           ack_n,
	output logic           perror,
	output logic           select,
	output logic           fault_n,
	output logic [7:0]     pd_in,
	output logic [7:0]     fwd_cnt,
	output logic [8:0]     fwd_last,
	output logic [1:0]     rev_cnt
);
	logic [1:0] ph;

	// idle: ready, forward, on line, no fault
	initial begin
		{busy, ack_n, perror, select, fault_n} = 5'h0F;
		pd_in = 8'hA5;
		fwd_cnt = 8'h00;
		fwd_last = 9'h000;
		rev_cnt = 2'h0;
		ph = 2'h0;
	end

	// forward latch or reverse byte supply
	always @(posedge pclk) begin
		if (init_n) begin
			perror <= 1'b1; // forward acknowledged
			fault_n <= !stall; // a stalled peripheral reports a fault
			pd_in <= ~pd_in; // lines not ours: keep them moving
			if (stall) begin
				busy <= 1'b1;
			end else if (!strobe_n && !busy) begin
				fwd_last <= {autofd_n, pd_out};
				fwd_cnt <= fwd_cnt + 8'h01;
				busy <= 1'b1;
			end else if (strobe_n) begin
				busy <= 1'b0; // ready for the next byte
			end
		end else begin
			perror <= 1'b0; // reverse acknowledged
			case (ph)
				2'h0: if (!perror && !autofd_n && rev_cnt < 2'h2) begin
					pd_in <= (rev_cnt == 2'h0) ? 8'h5A : 8'h12; // msb zero
					busy <= (rev_cnt == 2'h0); // high data, low command
					ph <= 2'h1;
				end
				2'h1: begin
					ack_n <= 1'b0; // data valid
					ph <= 2'h2;
				end
				default: if (autofd_n) begin
					ack_n <= 1'b1; // interlock closed
					pd_in <= ~pd_in;
					rev_cnt <= rev_cnt + 2'h1;
					ph <= 2'h0;
				end
			endcase
		end
	end
endmodule // periph_model
`default_nettype wire

// [testbench.sv]
// self-checking bench for the parallel port controller
`timescale 1ns/1ns
`default_nettype none

module testbench;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        dma_tc, irq_line_level, stall, pclk;
	logic [7:0]  awaddr, araddr, pd_out, pd_in, fwd_cnt;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, rev_cnt;
	logic        awready, wready, bvalid, arready, rvalid, pd_oe, strobe_n;
	logic        autofd_n, init_n, selectin_n, busy, ack_n, perror, select;
	logic        fault_n, dma_req, irq;
	logic [8:0]  fwd_last;
	int          miscompares, check_count, irq_cnt;

	ecp_parallel_port_fifo_ctrl ecp_parallel_port_fifo_ctrl_i (
		.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .pd_in, .pd_out, .pd_oe,
		.strobe_n, .autofd_n, .init_n, .selectin_n, .busy, .ack_n, .perror,
		.select, .fault_n, .dma_tc, .irq_line_level, .dma_req, .irq
	);
	periph_model periph_model_i (
		.pclk, .stall, .strobe_n, .autofd_n, .init_n, .pd_out, .busy, .ack_n,
		.perror, .select, .fault_n, .pd_in, .fwd_cnt, .fwd_last, .rev_cnt
	);

	// ============================================================
	// clocks: link clock unrelated in phase
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	initial begin
		pclk = 1'b0;
		#7;
		forever #200 pclk = ~pclk;
	end
	always @(posedge aclk) if (irq === 1'b1) irq_cnt <= irq_cnt + 1;

	// ============================================================
	// reporting
	task wrap_up;
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task tmo;
		miscompares++;
		$display("CHECK FAILED t=%0t wait ran out", $time);
		wrap_up;
	endtask

	// ============================================================
	// bus tasks: ready and answers looked at mid-cycle, taken at edge
	task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e);
		int n;
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		n = 0;
		do begin
			@(negedge aclk);
			n++;
		end while (!awready && n < 50);
		if (n == 50) tmo;
		@(posedge aclk);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		n = 0;
		do begin
			@(negedge aclk);
			n++;
		end while (!bvalid && n < 50);
		if (n == 50) tmo;
		chk({30'h0, bresp}, {30'h0, e});
		@(posedge aclk);
	endtask
	task rd(input logic [7:0] a, input logic [7:0] x, input logic [1:0] e);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		n = 0;
		do begin
			@(negedge aclk);
			n++;
		end while (!arready && n < 50);
		if (n == 50) tmo;
		@(posedge aclk);
		arvalid <= 1'b0;
		n = 0;
		do begin
			@(negedge aclk);
			n++;
		end while (!rvalid && n < 50);
		if (n == 50) tmo;
		chk(rdata, {24'h0, x});
		chk({30'h0, rresp}, {30'h0, e});
		@(posedge aclk);
	endtask
	// bounded wait on the peripheral's forward or reverse count
	task wait_cnt(input int c, input logic rev);
		int n;
		for (n = 0; n < 4000; n++) begin
			@(posedge aclk);
			if (rev ? (rev_cnt == c[1:0]) : (fwd_cnt >= c[7:0])) break;
		end
		if (n == 4000) tmo;
	endtask

	// ============================================================
	// main sequence
	initial begin
		{aresetn, awvalid, wvalid, arvalid, dma_tc, stall} = 6'h00;
		{bready, rready, irq_line_level} = 3'h7;
		{awaddr, araddr, wdata, wstrb} = {16'h0000, 32'h0, 4'hF};
		{miscompares, check_count, irq_cnt} = 0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(8'h1C, 8'h15, 2'h0);
		rd(8'h04, 8'hFF, 2'h0);
		rd(8'h08, 8'hC4, 2'h0);
		wr(8'h00, 8'h5C, 2'h0);
		rd(8'h00, 8'h5C, 2'h0);
		chk({24'h0, pd_out}, 32'h5C);
		chk({31'h0, selectin_n}, 32'h1);
		rd(8'h24, 8'h00, 2'h2);
		wr(8'h24, 8'h00, 2'h2);
		// configuration mode, then an illegal hop to fifo mode
		wr(8'h1C, 8'hF4, 2'h0);
		rd(8'h14, 8'h10, 2'h0);
		rd(8'h18, 8'h7F, 2'h0);
		wr(8'h1C, 8'h54, 2'h0);
		rd(8'h1C, 8'hF5, 2'h0);
		wr(8'h1C, 8'h14, 2'h0);
		// ecp forward: run length count, then its data byte
		wr(8'h08, 8'h04, 2'h0);
		wr(8'h1C, 8'h74, 2'h0);
		wr(8'h10, 8'h85, 2'h0);
		wr(8'h0C, 8'h3C, 2'h0);
		wait_cnt(1, 1'b0);
		chk({23'h0, fwd_last}, 32'h085);
		wait_cnt(2, 1'b0);
		chk({23'h0, fwd_last}, 32'h13C);
		rd(8'h1C, 8'h75, 2'h0);
		// stalled peripheral faults; fill past the sixteen entries
		wr(8'h1C, 8'h64, 2'h0);
		stall <= 1'b1;
		repeat (20) @(posedge aclk);
		for (int i = 0; i < 17; i++) wr(8'h0C, 8'(i), 2'h0);
		rd(8'h1C, 8'h66, 2'h0);
		stall <= 1'b0;
		wait_cnt(18, 1'b0);
		repeat (100) @(posedge aclk);
		chk({24'h0, fwd_cnt}, 32'd18);
		chk({23'h0, fwd_last}, 32'h10F);
		rd(8'h1C, 8'h65, 2'h0);
		// service flag: writes of one are silent, clearing rearms
		chk(irq_cnt, 1);
		wr(8'h1C, 8'h70, 2'h0);
		rd(8'h1C, 8'h75, 2'h0);
		chk(irq_cnt, 2);
		wr(8'h1C, 8'h78, 2'h0);
		rd(8'h1C, 8'h79, 2'h0);
		dma_tc <= 1'b1;
		@(posedge aclk);
		dma_tc <= 1'b0;
		rd(8'h1C, 8'h7D, 2'h0);
		chk({31'h0, dma_req}, 32'h0);
		// direction locked outside bidirectional mode
		wr(8'h08, 8'h24, 2'h0);
		rd(8'h08, 8'hC4, 2'h0);
		// reverse: via bidirectional mode, two bytes in
		wr(8'h1C, 8'h34, 2'h0);
		wr(8'h08, 8'h20, 2'h0);
		wr(8'h1C, 8'h74, 2'h0);
		wait_cnt(2, 1'b1);
		chk({31'h0, pd_oe}, 32'h0);
		// two bytes held: below the fill threshold, then above it
		wr(8'h1C, 8'h70, 2'h0);
		rd(8'h1C, 8'h70, 2'h0);
		wr(8'h20, 8'h08, 2'h0);
		rd(8'h1C, 8'h74, 2'h0);
		rd(8'h0C, 8'h5A, 2'h0);
		rd(8'h0C, 8'h12, 2'h0);
		rd(8'h1C, 8'h75, 2'h0);
		wrap_up;
	end
endmodule // testbench
`default_nettype wire
